// ---- sfp_dev.sv ----
// Behaviour
// - sample input on rise, drive output on fall
// - host holds chip enable low per command
// - both clock idle levels, same edges
// - shared pin is reset until pause enabled
// - pause function sticks until power cycle
// - host holds reset low 100 ns minimum
// - output floats during hardware reset
// - hardware reset restores status defaults
// - hardware reset aborts program or erase
// - hardware reset ends auto-increment, floats output
// - host waits recovery time after reset
// - pause entry waits for clock low
// - pause exit waits for clock low
// - paused: output floats, inputs ignored
// - pause keeps bit position intact
// - chip enable high abandons paused frame
// - host raises pause input to resume
// - status write refused when pin low, locked
// - protect pin high ignores lock bit
// - erase sizes 4K,16K,32K; 64K large parts
// - output shows ready/busy in auto-increment
// - lock blocks level and lock changes
// - lock clears, level bits set at power-up
//
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module sfp_dev
    import sfp_pkg::*;
#(
    parameter int PROG_CYC = 100,
    parameter int ERASE_CYC = 1000,
    parameter int DENSITY_MBIT = 4
) (
    // clock and power-on reset
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    // serial link
    sfp_if.dev link,
    // user-side status
    output logic [7:0] status_out,
    output logic pause_mode_out,
    output logic paused_out
);
    import sfp_pkg::*;
    localparam int CW = $clog2(ERASE_CYC + PROG_CYC + 1);

    logic [4:0] sy;
    logic sck_s, cs_s, si_s, wp_s, rp_s;
    logic sck_prev_reg, cs_prev_reg;
    logic rise, cs_rise, hw_rst, active;
    logic pause_mode_reg, paused_reg;
    logic [2:0] bit_cnt_reg, byte_cnt_reg;
    logic [7:0] sh_reg, cmd_reg, dat_reg, tx_reg, nb;
    sfp_dstate_t state_reg;
    logic wel_reg, lock_reg, auto_reg, hwbusy_reg;
    logic [2:0] level_reg;
    logic [CW-1:0] busy_cnt_reg;
    logic busy, exec;
    logic [7:0] status;

    sfp_sync #(.WIDTH(5)) u_sync (
        .ref_clk_in(ref_clk_in),
        .rst_b_in(rst_b_in),
        .d_in({link.sck, link.cs_n, link.si, link.wp_n, link.rst_pause_n}),
        .q_out(sy)
    );
    assign {sck_s, cs_s, si_s, wp_s, rp_s} = sy;

    function automatic logic is_erase(input logic [7:0] c);
        is_erase = (c == CMD_ERASE_4K) || (c == CMD_ERASE_16K)
            || (c == CMD_ERASE_32K)
            || (c == CMD_ERASE_64K && DENSITY_MBIT >= BIG_BLOCK_MBIT);
    endfunction

    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            sck_prev_reg <= 1'b0;
            cs_prev_reg <= 1'b1;
        end
        else
        begin
            sck_prev_reg <= sck_s;
            cs_prev_reg <= cs_s;
        end
    end

    // same edges whatever the idle level of the clock
    assign rise = sck_s && !sck_prev_reg;
    assign cs_rise = cs_s && !cs_prev_reg;
    assign hw_rst = !pause_mode_reg && !rp_s;
    assign active = !cs_s && !paused_reg && !hw_rst;
    assign nb = {sh_reg[6:0], si_s};
    assign busy = busy_cnt_reg != '0;
    assign status = {lock_reg, auto_reg, 1'b0, level_reg, wel_reg, busy};
    // a frame counts only if it ends on a byte boundary and not during a pause
    assign exec = cs_rise && !paused_reg && bit_cnt_reg == '0 && !hw_rst;

    // only the power-on reset brings the reset function back
    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            pause_mode_reg <= 1'b0;
        else if (exec && cmd_reg == CMD_ENABLE_PAUSE && byte_cnt_reg == LEN_OPCODE)
            pause_mode_reg <= 1'b1;
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            paused_reg <= 1'b0;
        else if (cs_s || !pause_mode_reg)
            paused_reg <= 1'b0;
        else if (!sck_s)
            paused_reg <= !rp_s;
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            bit_cnt_reg <= '0;
            byte_cnt_reg <= '0;
            sh_reg <= '0;
            cmd_reg <= '0;
            dat_reg <= '0;
            state_reg <= DS_CMD;
        end
        else if (hw_rst || cs_s)
        begin
            bit_cnt_reg <= '0;
            byte_cnt_reg <= '0;
            state_reg <= DS_CMD;
        end
        else if (active && rise)
        begin
            sh_reg <= nb;
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == BIT_LAST)
            begin
                byte_cnt_reg <= byte_cnt_reg + 3'h1;
                case (state_reg)
                    DS_CMD:
                    begin
                        cmd_reg <= nb;
                        if (nb == CMD_READ_STATUS)
                            state_reg <= DS_RDST;
                        else if (nb == CMD_WRITE_STATUS)
                            state_reg <= DS_DATA;
                        else if (nb == CMD_AUTO_INC && auto_reg)
                            state_reg <= DS_DATA;
                        else if (nb == CMD_PROG || nb == CMD_AUTO_INC
                            || is_erase(nb))
                            state_reg <= DS_ADDR;
                        else
                            state_reg <= DS_SKIP;
                    end
                    DS_ADDR:
                        if (byte_cnt_reg == LEN_ADDR_END)
                            state_reg <= is_erase(cmd_reg) ? DS_SKIP : DS_DATA;
                    DS_DATA:
                    begin
                        dat_reg <= nb;
                        state_reg <= DS_SKIP;
                    end
                    DS_RDST: state_reg <= DS_RDST;
                    DS_SKIP: state_reg <= DS_SKIP;
                    default: state_reg <= DS_SKIP;
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            wel_reg <= 1'b0;
            lock_reg <= 1'b0;
            level_reg <= LEVEL_DEFAULT;
            auto_reg <= 1'b0;
            hwbusy_reg <= 1'b0;
            busy_cnt_reg <= '0;
        end
        else if (hw_rst)
        begin
            wel_reg <= 1'b0;
            lock_reg <= 1'b0;
            level_reg <= LEVEL_DEFAULT;
            auto_reg <= 1'b0;
            busy_cnt_reg <= '0;
        end
        else
        begin
            if (busy)
                busy_cnt_reg <= busy_cnt_reg - 1'b1;
            if (exec && cmd_reg == CMD_WRITE_EN && !busy)
                wel_reg <= 1'b1;
            if (exec && cmd_reg == CMD_WRITE_DIS && !busy)
            begin
                wel_reg <= 1'b0;
                auto_reg <= 1'b0;
            end
            if (exec && cmd_reg == CMD_HW_BUSY_ON)
                hwbusy_reg <= 1'b1;
            if (exec && cmd_reg == CMD_HW_BUSY_OFF)
                hwbusy_reg <= 1'b0;
            if (exec && cmd_reg == CMD_WRITE_STATUS && !busy
                && byte_cnt_reg == LEN_STATUS_WR && wel_reg)
            begin
                wel_reg <= 1'b0;
                if (wp_s || !lock_reg)
                begin
                    lock_reg <= dat_reg[ST_LOCK];
                    level_reg <= dat_reg[ST_LVL2:ST_LVL0];
                end
            end
            if (exec && !busy && wel_reg && is_erase(cmd_reg)
                && byte_cnt_reg == LEN_ERASE)
            begin
                wel_reg <= 1'b0;
                busy_cnt_reg <= CW'(ERASE_CYC);
            end
            if (exec && !busy && wel_reg && byte_cnt_reg == LEN_PROG
                && (cmd_reg == CMD_PROG || cmd_reg == CMD_AUTO_INC)
                && !auto_reg)
            begin
                wel_reg <= cmd_reg == CMD_AUTO_INC;
                auto_reg <= cmd_reg == CMD_AUTO_INC;
                busy_cnt_reg <= CW'(PROG_CYC);
            end
            if (exec && !busy && auto_reg && cmd_reg == CMD_AUTO_INC
                && byte_cnt_reg == LEN_AUTO_NEXT)
                busy_cnt_reg <= CW'(PROG_CYC);
        end
    end

    // status read data changes only on falling clock, so the host sees it settled
    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            link.so <= 1'b0;
            link.so_oe_n <= 1'b1;
            tx_reg <= '0;
        end
        else if (hw_rst || cs_s || paused_reg)
            link.so_oe_n <= 1'b1;
        else if (auto_reg && hwbusy_reg && state_reg == DS_CMD
            && byte_cnt_reg == '0)
        begin
            link.so <= !busy;
            link.so_oe_n <= 1'b0;
        end
        else if (state_reg == DS_CMD && rise && bit_cnt_reg == BIT_LAST)
            tx_reg <= status;
        else if (state_reg == DS_RDST && sck_prev_reg && !sck_s)
        begin
            link.so <= tx_reg[7];
            link.so_oe_n <= 1'b0;
            tx_reg <= {tx_reg[6:0], tx_reg[7]};
        end
        // a status read drives the held bit again once a pause ends
        else
            link.so_oe_n <= state_reg != DS_RDST;
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            status_out <= '0;
            pause_mode_out <= 1'b0;
            paused_out <= 1'b0;
        end
        else
        begin
            status_out <= status;
            pause_mode_out <= pause_mode_reg;
            paused_out <= paused_reg;
        end
    end
endmodule

// ---- sfp_pkg.sv ----
package sfp_pkg;
    localparam int CLK_NS = 20;
    // opcodes
    localparam logic [7:0] CMD_WRITE_STATUS = 8'h01;
    localparam logic [7:0] CMD_PROG = 8'h02;
    localparam logic [7:0] CMD_WRITE_DIS = 8'h04;
    localparam logic [7:0] CMD_READ_STATUS = 8'h05;
    localparam logic [7:0] CMD_WRITE_EN = 8'h06;
    localparam logic [7:0] CMD_ERASE_4K = 8'h20;
    localparam logic [7:0] CMD_ERASE_16K = 8'h51;
    localparam logic [7:0] CMD_ERASE_32K = 8'h52;
    localparam logic [7:0] CMD_ERASE_64K = 8'hD8;
    localparam logic [7:0] CMD_AUTO_INC = 8'hAD;
    localparam logic [7:0] CMD_ENABLE_PAUSE = 8'hA7;
    localparam logic [7:0] CMD_HW_BUSY_ON = 8'h70;
    localparam logic [7:0] CMD_HW_BUSY_OFF = 8'h80;
    // byte counts checked in a frame, and the last bit index
    localparam logic [2:0] LEN_OPCODE = 3'h1;
    localparam logic [2:0] LEN_STATUS_WR = 3'h2;
    localparam logic [2:0] LEN_AUTO_NEXT = 3'h2;
    localparam logic [2:0] LEN_ADDR_END = 3'h3;
    localparam logic [2:0] LEN_ERASE = 3'h4;
    localparam logic [2:0] LEN_PROG = 3'h5;
    localparam logic [2:0] BIT_LAST = 3'h7;
    // status bit positions
    localparam int ST_BUSY = 0;
    localparam int ST_WEL = 1;
    localparam int ST_LVL0 = 2;
    localparam int ST_LVL2 = 4;
    localparam int ST_AUTO = 6;
    localparam int ST_LOCK = 7;
    localparam logic [2:0] LEVEL_DEFAULT = 3'h7;
    localparam int BIG_BLOCK_MBIT = 2;
    // timing
    localparam int TRST_NS = 100;
    localparam int TRST_CYC = (TRST_NS + CLK_NS - 1) / CLK_NS;
    localparam int TRECR_NS = 100;
    localparam int TRECR_CYC = (TRECR_NS + CLK_NS - 1) / CLK_NS;
    localparam int TRECP_US = 10;
    localparam int TRECP_CYC = (TRECP_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int TRECE_MS = 1;
    localparam int TRECE_CYC = (TRECE_MS * 1000000 + CLK_NS - 1) / CLK_NS;
    localparam int SCK_HALF = 4;
    // host register map
    localparam logic [7:0] HR_TX = 8'h00;
    localparam logic [7:0] HR_CTRL = 8'h04;
    localparam logic [7:0] HR_PINS = 8'h08;
    localparam logic [7:0] HR_STAT = 8'h0C;
    localparam logic [7:0] HR_RX = 8'h10;
    localparam int CT_GO = 0;
    localparam int CT_KEEP = 1;
    localparam int CT_MODE3 = 2;
    localparam int CT_RSTP = 3;
    localparam int CT_REC = 4;
    localparam int PN_RP = 0;
    localparam int PN_WP = 1;
    localparam int SA_BUSY = 0;
    localparam int SA_CS = 1;
    localparam logic [1:0] REC_READ = 2'h0;
    localparam logic [1:0] REC_PROG = 2'h1;
    typedef enum logic [4:0] {
        DS_CMD = 5'h01, DS_ADDR = 5'h02, DS_DATA = 5'h04,
        DS_RDST = 5'h08, DS_SKIP = 5'h10
    } sfp_dstate_t;
    typedef enum logic [3:0] {
        HS_IDLE = 4'h1, HS_LOW = 4'h2, HS_HIGH = 4'h4, HS_END = 4'h8
    } sfp_hstate_t;
endpackage

// ---- sfp_if.sv ----
`timescale 1ns/1ps
interface sfp_if;
    logic sck;
    logic cs_n;
    logic si;
    logic so;
    logic so_oe_n;
    logic wp_n;
    logic rst_pause_n;
    logic so_line;
    // pulled-up line when the device floats its output
    assign so_line = so_oe_n ? 1'b1 : so;
    modport dev (input sck, cs_n, si, wp_n, rst_pause_n, output so, so_oe_n);
    modport host (output sck, cs_n, si, wp_n, rst_pause_n, input so_line);
endinterface

// ---- sfp_sync.sv ----
`timescale 1ns/1ps
module sfp_sync #(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    input wire logic [WIDTH-1:0] d_in,
    output logic [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] meta_reg;
    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            meta_reg <= '0;
            q_out <= '0;
        end
        else
        begin
            meta_reg <= d_in;
            q_out <= meta_reg;
        end
    end
endmodule

// ---- sfp_host.sv ----
`timescale 1ns/1ps
module sfp_host
    import sfp_pkg::*;
#(
    parameter int HALF = SCK_HALF,
    parameter int RECE_CYC = TRECE_CYC
) (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    // serial link
    sfp_if.host link,
    // register port
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out
);
    import sfp_pkg::*;
    localparam int RW = $clog2(RECE_CYC + TRECP_CYC + 1);

    logic so_s;
    logic [7:0] tx_reg, rx_reg, sh_reg;
    logic keep_reg, mode3_reg, rp_reg;
    logic [1:0] rec_kind_reg;
    sfp_hstate_t state_reg;
    logic [7:0] half_cnt_reg;
    logic [2:0] bit_cnt_reg;
    logic [RW-1:0] pulse_cnt_reg, rec_cnt_reg;
    logic ctrl_wr, busy;

    sfp_sync #(.WIDTH(1)) u_sync (
        .ref_clk_in(ref_clk_in),
        .rst_b_in(rst_b_in),
        .d_in(link.so_line),
        .q_out(so_s)
    );

    assign ctrl_wr = wr_in && addr_in == HR_CTRL;
    assign busy = state_reg != HS_IDLE || pulse_cnt_reg != '0
        || rec_cnt_reg != '0;

    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            tx_reg <= '0;
            keep_reg <= 1'b0;
            mode3_reg <= 1'b0;
            rp_reg <= 1'b1;
            link.wp_n <= 1'b1;
            rec_kind_reg <= REC_READ;
        end
        else
        begin
            if (wr_in && addr_in == HR_TX)
                tx_reg <= wdata_in;
            if (ctrl_wr)
            begin
                keep_reg <= wdata_in[CT_KEEP];
                mode3_reg <= wdata_in[CT_MODE3];
                rec_kind_reg <= wdata_in[CT_REC+1:CT_REC];
            end
            if (wr_in && addr_in == HR_PINS)
            begin
                rp_reg <= wdata_in[PN_RP];
                link.wp_n <= wdata_in[PN_WP];
            end
        end
    end

    // reset pulse, then the recovery wait before any new frame
    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            pulse_cnt_reg <= '0;
            rec_cnt_reg <= '0;
            link.rst_pause_n <= 1'b1;
        end
        else
        begin
            link.rst_pause_n <= rp_reg && pulse_cnt_reg == '0;
            if (ctrl_wr && wdata_in[CT_RSTP] && !busy)
                pulse_cnt_reg <= RW'(TRST_CYC);
            else if (pulse_cnt_reg != '0)
            begin
                pulse_cnt_reg <= pulse_cnt_reg - 1'b1;
                if (pulse_cnt_reg == RW'(1))
                    rec_cnt_reg <= rec_kind_reg == REC_READ ? RW'(TRECR_CYC)
                        : rec_kind_reg == REC_PROG ? RW'(TRECP_CYC)
                        : RW'(RECE_CYC);
            end
            else if (rec_cnt_reg != '0)
                rec_cnt_reg <= rec_cnt_reg - 1'b1;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            state_reg <= HS_IDLE;
            link.sck <= 1'b0;
            link.cs_n <= 1'b1;
            link.si <= 1'b0;
            sh_reg <= '0;
            rx_reg <= '0;
            half_cnt_reg <= '0;
            bit_cnt_reg <= '0;
        end
        else
        begin
            if (half_cnt_reg != '0)
                half_cnt_reg <= half_cnt_reg - 8'h01;
            case (state_reg)
                HS_IDLE:
                begin
                    link.sck <= mode3_reg;
                    if (ctrl_wr && wdata_in[CT_GO] && !busy)
                    begin
                        link.cs_n <= 1'b0;
                        link.sck <= 1'b0;
                        link.si <= tx_reg[7];
                        sh_reg <= {tx_reg[6:0], 1'b0};
                        bit_cnt_reg <= '0;
                        half_cnt_reg <= 8'(HALF - 1);
                        state_reg <= HS_LOW;
                    end
                    else if (ctrl_wr && !wdata_in[CT_KEEP])
                        link.cs_n <= 1'b1;
                end
                HS_LOW:
                    if (half_cnt_reg == '0)
                    begin
                        link.sck <= 1'b1;
                        half_cnt_reg <= 8'(HALF - 1);
                        state_reg <= HS_HIGH;
                    end
                HS_HIGH:
                    if (half_cnt_reg == '0)
                    begin
                        // sampled late in the high phase to cover sync delay
                        half_cnt_reg <= 8'(HALF - 1);
                        if (bit_cnt_reg == BIT_LAST)
                        begin
                            link.sck <= mode3_reg;
                            rx_reg <= {sh_reg[6:0], so_s};
                            state_reg <= HS_END;
                        end
                        else
                        begin
                            link.sck <= 1'b0;
                            link.si <= sh_reg[7];
                            sh_reg <= {sh_reg[6:0], so_s};
                            bit_cnt_reg <= bit_cnt_reg + 3'h1;
                            state_reg <= HS_LOW;
                        end
                    end
                HS_END:
                    if (half_cnt_reg == '0)
                    begin
                        link.cs_n <= !keep_reg;
                        state_reg <= HS_IDLE;
                    end
                default: state_reg <= HS_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            rdata_out <= '0;
        else if (rd_in)
            case (addr_in)
                HR_TX: rdata_out <= tx_reg;
                HR_RX: rdata_out <= rx_reg;
                HR_STAT: rdata_out <= {6'h00, link.cs_n, busy};
                default: rdata_out <= '0;
            endcase
        else
            rdata_out <= '0;
    end
endmodule

// ---- sfp_props.sv ----
`timescale 1ns/1ps
module sfp_props (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    // link lines
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    input wire logic so,
    input wire logic so_oe_n,
    input wire logic rst_pause_n
);
    logic [7:0] sck_reg;
    logic fell_near;

    // sck history, for edges seen through the synchroniser delay
    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            sck_reg <= 8'h00;
        else
            sck_reg <= {sck_reg[6:0], sck};
    end
    assign fell_near = |(sck_reg[5:2] & ~sck_reg[4:1]);

    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_b_in);

    a_float_deselect: assert property (
        cs_n [*6] |-> so_oe_n) else $error("output driven while deselected");
    a_reset_floats: assert property (
        (!rst_pause_n && !sck) [*6] |-> so_oe_n)
        else $error("output driven while shared pin low");
    a_so_after_fall: assert property (
        $changed(so) && !so_oe_n && !$past(so_oe_n) |-> fell_near)
        else $error("output moved away from a falling clock");
    a_si_held_high: assert property (
        !cs_n && sck && $past(sck) |-> $stable(si))
        else $error("input data moved while clock high");
    a_idle_sck_still: assert property (
        cs_n && $past(cs_n) |-> $stable(sck))
        else $error("clock moved while deselected");
    a_sck_in_frame: assert property (
        $rose(sck) |-> !cs_n) else $error("clock rose outside a frame");
    a_sck_high_span: assert property (
        $rose(sck) |-> sck [*4]) else $error("clock high phase too short");
    a_sck_low_span: assert property (
        $fell(sck) |-> !sck [*4]) else $error("clock low phase too short");

    cover property (!so_oe_n && !cs_n);
    cover property ($fell(rst_pause_n) && !cs_n);
    cover property ($fell(rst_pause_n) && cs_n);
endmodule

// ---- spi_flash_pin_control_bench.sv ----
`timescale 1ns/1ps
module spi_flash_pin_control_bench;
    import sfp_pkg::*;
    logic ref_clk_in;
    logic rst_b_in;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;
    logic [7:0] status;
    logic pause_mode;
    logic paused;
    logic [7:0] cap;
    logic [7:0] rx;
    int bad_count;
    int checks;

    sfp_if link ();
    sfp_host #(.RECE_CYC(50)) i_sfp_host (.ref_clk_in(ref_clk_in),
        .rst_b_in(rst_b_in), .link(link), .addr_in(addr),
        .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata));
    // long erase so a reset lands well inside it
    sfp_dev #(.PROG_CYC(10), .ERASE_CYC(200), .DENSITY_MBIT(4)) i_sfp_dev (
        .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .link(link),
        .status_out(status), .pause_mode_out(pause_mode),
        .paused_out(paused));
    sfp_props i_sfp_props (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
        .sck(link.sck), .cs_n(link.cs_n), .si(link.si), .so(link.so),
        .so_oe_n(link.so_oe_n), .rst_pause_n(link.rst_pause_n));

    initial
    begin
        ref_clk_in = 1'b0;
        forever #(CLK_NS / 2) ref_clk_in = ~ref_clk_in;
    end

    always @(posedge link.sck)
    begin
        if (!link.cs_n)
            cap <= {cap[6:0], link.si};
    end

    task chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task put(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk_in);
        wr <= 1'b0;
    endtask

    task get(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk_in);
        rd <= 1'b0;
        @(negedge ref_clk_in);
        d = rdata;
    endtask

    // one byte; ctl carries keep and mode bits
    task xfer(input logic [7:0] b, input logic [7:0] ctl);
        int n;
        put(HR_TX, b);
        put(HR_CTRL, ctl | 8'h01);
        rx = 8'h01;
        n = 0;
        while (rx[SA_BUSY] === 1'b1 && n < 100)
        begin
            get(HR_STAT, rx);
            n++;
        end
        if (n == 100)
            bad_count++;
        // the command takes effect a few cycles after chip enable rises
        repeat (4) @(posedge ref_clk_in);
        get(HR_RX, rx);
    endtask

    task rdsr(input logic [7:0] m, input logic [7:0] exp);
        xfer(CMD_READ_STATUS, m | 8'h02);
        chk(cap, CMD_READ_STATUS);
        xfer(8'h00, m);
        chk(rx, exp);
        chk(status, exp);
    endtask

    task write_status_cmd(input logic [7:0] v);
        xfer(CMD_WRITE_EN, 8'h00);
        xfer(CMD_WRITE_STATUS, 8'h02);
        xfer(v, 8'h00);
        repeat (8) @(posedge ref_clk_in);
    endtask

    task pin_pause(input logic [7:0] mask);
        put(HR_PINS, 8'h02);
        repeat (6) @(posedge ref_clk_in);
        chk({7'h00, paused}, mask);
    endtask

    task give_verdict;
        if (bad_count == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial
    begin
        #(CLK_NS * 20000);
        bad_count++;
        give_verdict();
    end

    initial
    begin
        rst_b_in = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        bad_count = 0;
        checks = 0;
        repeat (4) @(posedge ref_clk_in);
        rst_b_in <= 1'b1;
        @(posedge ref_clk_in);
        @(negedge ref_clk_in);
        chk(status, 8'h1C);
        rdsr(8'h00, 8'h1C);
        rdsr(8'h04, 8'h1C);
        write_status_cmd(8'h80);
        chk(status, 8'h80);
        put(HR_PINS, 8'h01);
        write_status_cmd(8'h9C);
        chk(status, 8'h80);
        put(HR_PINS, 8'h03);
        write_status_cmd(8'h00);
        chk(status, 8'h00);
        put(HR_PINS, 8'h01);
        write_status_cmd(8'h08);
        chk(status, 8'h08);
        xfer(CMD_WRITE_EN, 8'h00);
        xfer(CMD_ERASE_4K, 8'h02);
        xfer(8'h00, 8'h02);
        xfer(8'h00, 8'h02);
        xfer(8'h00, 8'h00);
        repeat (4) @(posedge ref_clk_in);
        chk({7'h00, status[ST_BUSY]}, 8'h01);
        // open a status read so the output is driven when reset hits
        xfer(CMD_READ_STATUS, 8'h02);
        chk({7'h00, link.so_oe_n}, 8'h00);
        put(HR_PINS, 8'h00);
        repeat (6) @(posedge ref_clk_in);
        chk({7'h00, link.so_oe_n}, 8'h01);
        put(HR_PINS, 8'h03);
        put(HR_CTRL, 8'h00);
        // recovery wait before the next command
        repeat (60) @(posedge ref_clk_in);
        chk(status, 8'h1C);
        // host-timed reset pulse with erase recovery
        xfer(CMD_WRITE_EN, 8'h00);
        put(HR_CTRL, 8'h28);
        repeat (40) @(posedge ref_clk_in);
        get(HR_STAT, rx);
        chk(rx, 8'h03);
        repeat (20) @(posedge ref_clk_in);
        get(HR_STAT, rx);
        chk(rx, 8'h02);
        chk(status, 8'h1C);
        xfer(CMD_ENABLE_PAUSE, 8'h00);
        chk({7'h00, pause_mode}, 8'h01);
        xfer(CMD_WRITE_EN, 8'h00);
        pin_pause(8'h00);
        put(HR_PINS, 8'h03);
        repeat (4) @(posedge ref_clk_in);
        chk(status, 8'h1E);
        chk({7'h00, pause_mode}, 8'h01);
        xfer(CMD_READ_STATUS, 8'h02);
        pin_pause(8'h01);
        chk({7'h00, link.so_oe_n}, 8'h01);
        put(HR_PINS, 8'h03);
        repeat (6) @(posedge ref_clk_in);
        chk({7'h00, paused}, 8'h00);
        xfer(8'h00, 8'h00);
        chk(rx, 8'h1E);
        xfer(CMD_READ_STATUS, 8'h06);
        pin_pause(8'h00);
        put(HR_PINS, 8'h03);
        xfer(8'h00, 8'h04);
        chk(rx, 8'h1E);
        xfer(CMD_READ_STATUS, 8'h02);
        pin_pause(8'h01);
        put(HR_CTRL, 8'h00);
        repeat (6) @(posedge ref_clk_in);
        chk({7'h00, paused}, 8'h00);
        put(HR_PINS, 8'h03);
        rdsr(8'h00, 8'h1E);
        give_verdict();
    end
endmodule
